// file: rtl/irqf_pkg.sv
// constants, register map and types of the interrupt request flag logic
// assumes a 32-bit AXI4-Lite register bus and one 125 MHz clock
package irqf_pkg;
  localparam int NUM_SRC = 29;
  localparam int PAD_W = 32 - NUM_SRC;
  localparam int IDX_W = 5;
  localparam int ADDR_W = 8;

  localparam logic [ADDR_W-1:0] OFS_REQ = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PRIO = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_REQ_SET = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_REQ_CLR = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;

  localparam logic [NUM_SRC-1:0] REQ_RST = 29'h0000_0000;
  localparam logic [NUM_SRC-1:0] MASK_RST = 29'h1fff_ffff;
  localparam logic [NUM_SRC-1:0] PRIO_RST = 29'h1fff_ffff;
  localparam logic CTRL_IE_RST = 1'b0;
  localparam logic CTRL_NMI_SEL_RST = 1'b0;
  localparam logic CTRL_INTERVAL_RST = 1'b0;
  localparam logic ISP_RST = 1'b1;

  localparam int CTRL_IE_BIT = 0;
  localparam int CTRL_NMI_SEL_BIT = 1;
  localparam int CTRL_INTERVAL_BIT = 2;
  localparam int STAT_SERV_BIT = 0;
  localparam int STAT_ISP_BIT = 1;
  localparam int STAT_NMI_SERV_BIT = 2;
  localparam int STAT_PEND_BIT = 3;
  localparam int STAT_IDX_LSB = 8;

  localparam int WDT_POS = 0;
  localparam int TM2_POS = 20;
  localparam int RTO_POS = 23;
  localparam int SMP0_POS = 24;

  localparam logic [15:0] VEC_BASE = 16'h0004;
  localparam logic [15:0] NMI_VEC = 16'h0004;
  localparam logic [15:0] TM2_VEC = 16'h002c;
  localparam logic [15:0] RTO_VEC = 16'h0032;
  localparam logic [15:0] SMP0_VEC = 16'h0034;
  localparam logic [15:0] SMP4_VEC = 16'h003c;
  localparam logic [15:0] BRK_VEC = 16'h003e;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {IRQF_NONE, IRQF_NMI, IRQF_BRK, IRQF_MASKABLE} irqf_kind_e;
endpackage

// file: rtl/irqf_first_set.sv
// lowest-index set bit finder for the default order
// assumes nothing; purely combinational
`timescale 1ns/100ps
module irqf_first_set
  import irqf_pkg::*;
#(
  parameter int W = NUM_SRC
)
(
  input wire logic [W-1:0] req,
  output logic found,
  output logic [IDX_W-1:0] idx
);
  always_comb
  begin
    found = 1'b0;
    idx = '0;
    for (int i = W - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        found = 1'b1;
        idx = IDX_W'(i);
      end
    end
  end
endmodule

// file: rtl/irqf_axil_slave.sv
// AXI4-Lite slave front end: one write and one read at a time
// assumes the register file answers rd_data/rd_ok/wr_ok combinationally
`timescale 1ns/100ps
module irqf_axil_slave
  import irqf_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_pulse,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  logic aw_have_r;
  logic w_have_r;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic aw_have_nxt;
  logic w_have_nxt;

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign wr_pulse = aw_have_r & w_have_r & ~s_axi_bvalid;
  assign aw_have_nxt = (aw_have_r & ~wr_pulse) | aw_take;
  assign w_have_nxt = (w_have_r & ~wr_pulse) | w_take;
  assign rd_addr = {s_axi_araddr[ADDR_W-1:2], 2'b00};

  // write address and data are latched independently
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end
    else
    begin
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      s_axi_awready <= ~aw_have_nxt;
      s_axi_wready <= ~w_have_nxt;
      if (aw_take)
        wr_addr <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
      if (w_take)
      begin
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
    end
  end

  // write response once both halves have been used
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (wr_pulse)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // read path: data captured when the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~(ar_take | (s_axi_rvalid & ~s_axi_rready));
      if (ar_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// file: rtl/irqf_top.sv
// request flags, masks, priorities and vectoring toward the cpu core
// assumes single-cycle source pulses, cpu ack/done pulses, AXI4-Lite master
// Notes on behaviour
// (RL1) fixed default order, position 0 highest
// (RL2) timer2, sampling a/b vectors 002c-0030
// (RL3) real-time reload request vectors to 0032
// (RL4) five sampling inputs vector 0034 to 003c
// (RL5) software break unmasked, vectors to 003e
// (RL6) watchdog either non-maskable or maskable, one
// (RL7) flags set by source or software write
// (RL8) acknowledge clears served flag before service
// (RL9) all request bytes reset to zero
// (RL10) request bytes take bit and byte access
// (RL11) byte pairs form two 16-bit request words
// (RL12) one request, mask, priority bit per source
// (RL13) watchdog flag accessible only in interval mode
// (RL14) software clears watchdog flag in mode 1
// (RL15) software clears flags after standby release
// (RL16) mask one disables; masks reset all ones
// (RL17) serve only set, unmasked, enabled; nesting waits
// (RL18) high priority level first, then default order
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
module irqf_top
  import irqf_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic watchdog_irq,
  input wire logic [18:0] peripheral_irq,
  input wire logic general_timer2_match_irq,
  input wire logic sampling_timer_a_irq,
  input wire logic sampling_timer_b_irq,
  input wire logic realtime_output_reload_irq,
  input wire logic [4:0] sampling_input_irq,
  input wire logic software_break,
  input wire logic irq_ack,
  input wire logic service_done,
  output logic irq_req_r,
  output logic [15:0] irq_vector_r
);
  logic [NUM_SRC-1:0] flags_r;
  logic [NUM_SRC-1:0] flags_nxt;
  logic [NUM_SRC-1:0] mask_r;
  logic [NUM_SRC-1:0] prio_r;
  logic ie_r;
  logic nmi_sel_r;
  logic interval_r;
  logic isp_r;
  logic in_service_r;
  logic nmi_pend_r;
  logic nmi_serv_r;
  logic brk_pend_r;
  irqf_kind_e kind_r;
  logic [IDX_W-1:0] sel_idx_r;
  logic wr_pulse;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  logic [NUM_SRC-1:0] src_ev;
  logic [NUM_SRC-1:0] elig;
  logic [NUM_SRC-1:0] hi_c;
  logic [NUM_SRC-1:0] lo_c;
  logic hi_found;
  logic lo_found;
  logic [IDX_W-1:0] hi_idx;
  logic [IDX_W-1:0] lo_idx;
  logic [IDX_W-1:0] pick_idx;
  logic ack_take;
  logic ack_mask;
  logic ack_nmi;
  logic ack_brk;
  logic [31:0] req_word;

  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        res[8*b +: 8] = data[8*b +: 8];
    return res;
  endfunction

  irqf_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_pulse(wr_pulse),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // source positions, watchdog only when maskable type selected
  assign src_ev = {sampling_input_irq, realtime_output_reload_irq, sampling_timer_b_irq,
                   sampling_timer_a_irq, general_timer2_match_irq, peripheral_irq,
                   watchdog_irq & ~nmi_sel_r}; // RL12 RL6 RL3 RL4
  assign ack_take = irq_ack & irq_req_r;
  assign ack_mask = ack_take & (kind_r == IRQF_MASKABLE);
  assign ack_nmi = ack_take & (kind_r == IRQF_NMI);
  assign ack_brk = ack_take & (kind_r == IRQF_BRK);
  assign wr_ok = (wr_addr == OFS_REQ) | (wr_addr == OFS_MASK) | (wr_addr == OFS_PRIO) |
                 (wr_addr == OFS_CTRL) | (wr_addr == OFS_REQ_SET) | (wr_addr == OFS_REQ_CLR);
  assign req_word = lane_merge({{PAD_W{1'b0}}, flags_r}, wr_data, wr_strb); // RL10 RL11

  // flag update: software, then ack clear, then source sets win
  always_comb
  begin
    flags_nxt = flags_r;
    if (wr_pulse && wr_addr == OFS_REQ)
      flags_nxt = req_word[NUM_SRC-1:0]; // RL7 RL11
    if (wr_pulse && wr_addr == OFS_REQ_SET)
      flags_nxt = flags_nxt | wr_data[NUM_SRC-1:0]; // RL10
    if (wr_pulse && wr_addr == OFS_REQ_CLR)
      flags_nxt = flags_nxt & ~wr_data[NUM_SRC-1:0]; // RL10
    if (!interval_r)
      flags_nxt[WDT_POS] = flags_r[WDT_POS]; // RL13
    if (ack_mask)
      flags_nxt[sel_idx_r] = 1'b0; // RL8
    flags_nxt = flags_nxt | src_ev; // RL7
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flags_r <= REQ_RST; // RL9
    else
      flags_r <= flags_nxt;
  end

  // mask and priority bytes, unimplemented bits stay one
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mask_r <= MASK_RST; // RL16
      prio_r <= PRIO_RST;
    end
    else if (wr_pulse && wr_addr == OFS_MASK)
      mask_r <= NUM_SRC'(lane_merge({{PAD_W{1'b1}}, mask_r}, wr_data, wr_strb));
    else if (wr_pulse && wr_addr == OFS_PRIO)
      prio_r <= NUM_SRC'(lane_merge({{PAD_W{1'b1}}, prio_r}, wr_data, wr_strb));
  end

  // control bits; enable drops on an acknowledge unless a control write lands in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ie_r <= CTRL_IE_RST;
      nmi_sel_r <= CTRL_NMI_SEL_RST;
      interval_r <= CTRL_INTERVAL_RST;
    end
    else if (wr_pulse && wr_addr == OFS_CTRL && wr_strb[0])
    begin
      ie_r <= wr_data[CTRL_IE_BIT];
      nmi_sel_r <= wr_data[CTRL_NMI_SEL_BIT]; // RL6
      interval_r <= wr_data[CTRL_INTERVAL_BIT];
    end
    else if (ack_take)
      ie_r <= 1'b0;
  end

  // service state and pending non-maskable and break requests
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      isp_r <= ISP_RST;
      in_service_r <= 1'b0;
      nmi_pend_r <= 1'b0;
      nmi_serv_r <= 1'b0;
      brk_pend_r <= 1'b0;
    end
    else
    begin
      nmi_pend_r <= (nmi_pend_r & ~ack_nmi) | (watchdog_irq & nmi_sel_r); // RL6
      brk_pend_r <= (brk_pend_r & ~ack_brk) | software_break; // RL5
      if (ack_take)
      begin
        in_service_r <= 1'b1;
        isp_r <= ack_mask ? prio_r[sel_idx_r] : 1'b0; // RL17
        if (ack_nmi)
          nmi_serv_r <= 1'b1;
      end
      else if (service_done)
      begin
        if (nmi_serv_r)
          nmi_serv_r <= 1'b0;
        else
        begin
          isp_r <= 1'b1;
          in_service_r <= 1'b0;
        end
      end
    end
  end

  // candidates: high level first, low level waits behind high service
  assign elig = flags_r & ~mask_r & {NUM_SRC{ie_r}}; // RL17 RL16
  assign hi_c = elig & ~prio_r; // RL18
  assign lo_c = elig & prio_r & {NUM_SRC{isp_r}}; // RL17

  irqf_first_set #(.W(NUM_SRC)) u_hi (
    .req(hi_c),
    .found(hi_found),
    .idx(hi_idx)
  );

  irqf_first_set #(.W(NUM_SRC)) u_lo (
    .req(lo_c),
    .found(lo_found),
    .idx(lo_idx)
  );

  assign pick_idx = hi_found ? hi_idx : lo_idx; // RL18 RL1

  // request and vector toward the cpu, withdrawn in the ack cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_req_r <= 1'b0;
      irq_vector_r <= '0;
      kind_r <= IRQF_NONE;
      sel_idx_r <= '0;
    end
    else if (ack_take)
    begin
      irq_req_r <= 1'b0;
      kind_r <= IRQF_NONE;
    end
    else if (nmi_pend_r && !nmi_serv_r)
    begin
      irq_req_r <= 1'b1;
      irq_vector_r <= NMI_VEC;
      kind_r <= IRQF_NMI;
    end
    else if (brk_pend_r)
    begin
      irq_req_r <= 1'b1;
      irq_vector_r <= BRK_VEC; // RL5
      kind_r <= IRQF_BRK;
    end
    else if (hi_found || lo_found)
    begin
      irq_req_r <= 1'b1;
      irq_vector_r <= VEC_BASE + {10'h000, pick_idx, 1'b0}; // RL2 RL3 RL4
      kind_r <= IRQF_MASKABLE;
      sel_idx_r <= pick_idx;
    end
    else
    begin
      irq_req_r <= 1'b0;
      kind_r <= IRQF_NONE;
    end
  end

  // register read mux
  always_comb
  begin
    rd_data = '0;
    rd_ok = 1'b1;
    case (rd_addr)
      OFS_REQ: rd_data = {{PAD_W{1'b0}}, flags_r[NUM_SRC-1:1],
                          flags_r[WDT_POS] & interval_r}; // RL13
      OFS_MASK: rd_data = {{PAD_W{1'b1}}, mask_r};
      OFS_PRIO: rd_data = {{PAD_W{1'b1}}, prio_r};
      OFS_CTRL: rd_data = {29'h0000_0000, interval_r, nmi_sel_r, ie_r};
      OFS_REQ_SET: rd_data = '0;
      OFS_REQ_CLR: rd_data = '0;
      OFS_STATUS:
      begin
        rd_data[STAT_SERV_BIT] = in_service_r;
        rd_data[STAT_ISP_BIT] = isp_r;
        rd_data[STAT_NMI_SERV_BIT] = nmi_serv_r;
        rd_data[STAT_PEND_BIT] = irq_req_r;
        rd_data[STAT_IDX_LSB +: IDX_W] = sel_idx_r;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  // checks
  logic [NUM_SRC-1:0] hi_q_r;
  logic [NUM_SRC-1:0] lo_q_r;
  logic [NUM_SRC-1:0] elig_q;
  logic [NUM_SRC-1:0] below_sel;
  always_ff @(posedge aclk)
  begin
    hi_q_r <= hi_c;
    lo_q_r <= lo_c;
  end
  assign elig_q = hi_q_r | lo_q_r;
  assign below_sel = (29'h0000_0001 << sel_idx_r) - 29'h0000_0001;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  flags_reset_a: assert property (disable iff (1'b0) // RL9
    !aresetn |=> flags_r == REQ_RST && mask_r == MASK_RST)
    else $error("flags or masks not at reset value");
  event_sets_a: assert property (|src_ev[NUM_SRC-1:1] |=> // RL7
    (flags_r[NUM_SRC-1:1] & $past(src_ev[NUM_SRC-1:1])) == $past(src_ev[NUM_SRC-1:1]))
    else $error("source event did not set its flag");
  ack_clears_a: assert property (ack_mask && !src_ev[sel_idx_r] && !wr_pulse |=> // RL8
    !flags_r[$past(sel_idx_r)] && !irq_req_r)
    else $error("acknowledged flag still set");
  served_eligible_a: assert property (irq_req_r && kind_r == IRQF_MASKABLE |-> // RL17
    elig_q[sel_idx_r])
    else $error("vectored a masked or disabled request");
  high_first_a: assert property (irq_req_r && kind_r == IRQF_MASKABLE && hi_q_r != '0 |-> // RL18
    hi_q_r[sel_idx_r])
    else $error("low level chosen over high level");
  default_order_a: assert property (irq_req_r && kind_r == IRQF_MASKABLE |-> // RL1
    (((hi_q_r != '0) ? hi_q_r : lo_q_r) & below_sel) == '0)
    else $error("default order not kept");
  timer2_vec_a: assert property (irq_req_r && kind_r == IRQF_MASKABLE && // RL2
    sel_idx_r == IDX_W'(TM2_POS) |-> irq_vector_r == TM2_VEC)
    else $error("timer2 vector wrong");
  reload_vec_a: assert property (irq_req_r && kind_r == IRQF_MASKABLE && // RL3
    sel_idx_r == IDX_W'(RTO_POS) |-> irq_vector_r == RTO_VEC)
    else $error("reload vector wrong");
  sampling_vec_a: assert property (irq_req_r && kind_r == IRQF_MASKABLE && // RL4
    sel_idx_r >= IDX_W'(SMP0_POS) |-> irq_vector_r >= SMP0_VEC && irq_vector_r <= SMP4_VEC)
    else $error("sampling input vector out of range");
  break_vec_a: assert property (irq_req_r && kind_r == IRQF_BRK |-> // RL5
    irq_vector_r == BRK_VEC && $past(brk_pend_r))
    else $error("break vector wrong");
  nmi_select_a: assert property (watchdog_irq && nmi_sel_r && !flags_r[WDT_POS] && !wr_pulse // RL6
    |=> !flags_r[WDT_POS] && nmi_pend_r)
    else $error("watchdog took the wrong type");
  wdt_hidden_a: assert property (!interval_r && rd_addr == OFS_REQ |-> !rd_data[WDT_POS]) // RL13
    else $error("watchdog flag visible outside interval mode");

  mask_ack_c: cover property (ack_mask ##1 service_done);
  nmi_ack_c: cover property (ack_nmi);
  brk_ack_c: cover property (ack_brk);
  nested_c: cover property (ack_mask ##[1:20] ack_mask);
endmodule

// file: test/irqf_cpu_model.sv
// cpu core stand-in: takes presented requests, services them, returns
// assumes irq_req_r/irq_vector_r registered on aclk, synchronous active-low reset
`timescale 1ns/100ps
module irqf_cpu_model
#(
  parameter int SVC = 20
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic irq_req_r,
  input wire logic [15:0] irq_vector_r,
  input wire logic [3:0] ack_delay,
  output logic irq_ack,
  output logic service_done,
  output logic busy,
  output logic [15:0] last_vec,
  output int acks
);
  int wait_cnt;
  int svc_cnt;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_ack <= 1'b0;
      service_done <= 1'b0;
      busy <= 1'b0;
      last_vec <= 16'h0000;
      acks <= 0;
      wait_cnt <= 0;
      svc_cnt <= 0;
    end
    else
    begin
      service_done <= 1'b0;
      if (irq_ack)
      begin
        // vector taken with the ack; service starts after the flag clears
        irq_ack <= 1'b0;
        last_vec <= irq_vector_r;
        acks <= acks + 1;
        busy <= 1'b1;
        svc_cnt <= 0;
      end
      else if (busy)
      begin
        svc_cnt <= svc_cnt + 1;
        busy <= (svc_cnt != SVC - 1);
        service_done <= (svc_cnt == SVC - 1);
      end
      else if (irq_req_r)
      begin
        // prompt or slow acceptance as the bench asks
        irq_ack <= (wait_cnt >= int'(ack_delay));
        wait_cnt <= (wait_cnt >= int'(ack_delay)) ? 0 : wait_cnt + 1;
      end
    end
  end
endmodule

// file: test/interrupt_request_flag_logic_tb.sv
// self-checking bench for the interrupt request flag logic
// assumes irqf_top as design and irqf_cpu_model as the cpu side
`timescale 1ns/100ps
module interrupt_request_flag_logic_tb;
  import irqf_pkg::*;
  logic aclk, aresetn;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, ack_delay;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [28:0] src;
  logic software_break, irq_ack, service_done, irq_req_r, busy;
  logic [15:0] irq_vector_r, last_vec;
  int acks, miscompares, checked;

  irqf_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .watchdog_irq(src[0]),
    .peripheral_irq(src[19:1]), .general_timer2_match_irq(src[20]),
    .sampling_timer_a_irq(src[21]), .sampling_timer_b_irq(src[22]),
    .realtime_output_reload_irq(src[23]), .sampling_input_irq(src[28:24]),
    .software_break, .irq_ack, .service_done, .irq_req_r, .irq_vector_r);

  irqf_cpu_model cpu_u (.aclk, .aresetn, .irq_req_r, .irq_vector_r, .ack_delay, .irq_ack,
    .service_done, .busy, .last_vec, .acks);

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    bit aw, w;
    int n;
    aw = 0;
    w = 0;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (n < 100 && !(aw && w && s_axi_bvalid === 1'b1))
    begin
      @(posedge aclk);
      n++;
      aw = aw || (s_axi_awready === 1'b1);
      w = w || (s_axi_wready === 1'b1);
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    chk("write done", 32'h1, {31'h0, n < 100});
  endtask

  task automatic rdr(input logic [7:0] a);
    bit ar;
    int n;
    ar = 0;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      ar = ar || (s_axi_arready === 1'b1);
      s_axi_arvalid <= !ar;
    end
    while (n < 100 && s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk("read done", 32'h1, {31'h0, n < 100});
  endtask

  task automatic pulse_src(input int p);
    src[p] <= 1'b1;
    @(posedge aclk);
    src <= '0;
  endtask

  task automatic expect_vec(input logic [15:0] v);
    int n0, n;
    n0 = acks;
    n = 0;
    while (acks == n0 && n < 200)
    begin
      @(posedge aclk);
      n++;
    end
    chk("ack seen", 32'h1, {31'h0, n < 200});
    chk("vector", {16'h0, v}, {16'h0, last_vec});
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    repeat (2) @(posedge aclk);
    while (busy !== 1'b0 && n < 200)
    begin
      @(posedge aclk);
      n++;
    end
    repeat (2) @(posedge aclk);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  initial
  begin
    repeat (30000) @(posedge aclk);
    miscompares++;
    $display("BAD run_time exp done got timeout");
    tally_and_finish();
  end

  initial
  begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = '0;
    ack_delay = '0;
    src = '0;
    software_break = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdr(OFS_REQ); chk("req reset", 32'h0, rd);
    rdr(OFS_MASK); chk("mask reset", 32'hffffffff, rd);
    rdr(OFS_PRIO); chk("prio reset", 32'hffffffff, rd);
    rdr(8'h40); chk("unmapped rd", {30'h0, RESP_SLVERR}, {30'h0, rs});
    wr(8'h40, 32'h1); chk("unmapped wr", {30'h0, RESP_SLVERR}, {30'h0, rs});
    wr(OFS_REQ, 32'hffffffff, 4'b0100);
    rdr(OFS_REQ); chk("req byte2", 32'h00ff0000, rd);
    wr(OFS_REQ, 32'h0000a5ff, 4'b0011);
    rdr(OFS_REQ); chk("req word0", 32'h00ffa5fe, rd);
    wr(OFS_REQ, 32'hff000000, 4'b1000);
    rdr(OFS_REQ); chk("req byte3", 32'h1fffa5fe, rd);
    wr(OFS_CTRL, 32'h5);
    wr(OFS_REQ_SET, 32'h1);
    rdr(OFS_REQ); chk("wdt flag", 32'h1fffa5ff, rd);
    chk("all masked", 32'h0, {31'h0, irq_req_r});
    wr(OFS_REQ_CLR, 32'h1fffffff);
    rdr(OFS_REQ); chk("req clear", 32'h0, rd);
    for (int p = 0; p < NUM_SRC; p++)
    begin
      ack_delay <= 4'(p % 4);
      wr(OFS_MASK, ~(32'h1 << p));
      wr(OFS_CTRL, 32'h4);
      pulse_src(p);
      repeat (3) @(posedge aclk);
      chk("ie off", 32'h0, {31'h0, irq_req_r});
      rdr(OFS_REQ); chk("src flag", 32'h1 << p, rd);
      wr(OFS_CTRL, 32'h5);
      expect_vec(16'h0004 + 16'(2 * p));
      rdr(OFS_REQ); chk("ack clear", 32'h0, rd);
      wait_idle();
    end
    wr(OFS_MASK, 32'h0);
    wr(OFS_CTRL, 32'h4);
    wr(OFS_REQ_SET, 32'h10000020);
    wr(OFS_CTRL, 32'h5);
    expect_vec(16'h000e);
    wait_idle();
    wr(OFS_CTRL, 32'h5);
    expect_vec(16'h003c);
    wait_idle();
    wr(OFS_PRIO, 32'hefffffff);
    wr(OFS_CTRL, 32'h4);
    wr(OFS_REQ_SET, 32'h10000020);
    wr(OFS_CTRL, 32'h5);
    expect_vec(16'h003c);
    wr(OFS_CTRL, 32'h5);
    repeat (2) @(posedge aclk);
    chk("nest wait", 32'h0, {31'h0, irq_req_r});
    rdr(OFS_STATUS); chk("status", 32'h00001c01, rd);
    expect_vec(16'h000e);
    wait_idle();
    wr(OFS_MASK, 32'hffffffff);
    wr(OFS_CTRL, 32'h0);
    software_break <= 1'b1;
    @(posedge aclk);
    software_break <= 1'b0;
    expect_vec(16'h003e);
    wait_idle();
    wr(OFS_CTRL, 32'h6);
    pulse_src(0);
    expect_vec(NMI_VEC);
    wait_idle();
    rdr(OFS_REQ); chk("nmi no flag", 32'h0, rd);
    tally_and_finish();
  end
endmodule
